//--- inc/fsag_pkg.sv
// Package: constants and types of the flash sector access guard
package fsag_pkg;

  // ************************************************************
  // Register map (byte addresses, 32-bit APB words)
  // ************************************************************
  localparam logic [11:0] FSAG_ADDR_CTRL   = 12'h024;  // flash_program_control
  localparam logic [11:0] FSAG_ADDR_STATUS = 12'h028;
  localparam logic [11:0] FSAG_ADDR_ADDR   = 12'h02C;
  localparam logic [11:0] FSAG_ADDR_DATA   = 12'h030;
  localparam logic [11:0] FSAG_ADDR_OPTION = 12'h034;
  localparam logic [11:0] FSAG_ADDR_RDATA  = 12'h038;
  localparam logic [7:0]  FSAG_CTRL_RESET  = 8'h00;

  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int FSAG_CTRL_PROG  = 0;  // Program one byte
  localparam int FSAG_CTRL_SERASE = 1; // Erase sector
  localparam int FSAG_CTRL_MERASE = 2; // Erase whole array
  localparam int FSAG_CTRL_OPTWR = 3;  // Write option byte
  localparam int FSAG_CTRL_READ  = 4;  // Read one byte

  // Option byte field: read-out protection
  localparam int FSAG_OPT_LOCK = 0;

  // ************************************************************
  // Array geometry
  // ************************************************************
  localparam logic [15:0] FSAG_SECTOR0_BASE = 16'hF000;
  localparam logic [15:0] FSAG_SECTOR1_BASE = 16'hE000;
  localparam int          FSAG_SECTOR_BYTES = 4096;
  localparam int          FSAG_SIZE_4K      = 4096;
  localparam int          FSAG_SIZE_8K      = 8192;
  localparam logic [7:0]  FSAG_ERASED_BYTE  = 8'hFF;

  // Status error codes
  localparam logic [1:0] FSAG_ERR_NONE    = 2'h0;
  localparam logic [1:0] FSAG_ERR_LOCKED  = 2'h1;
  localparam logic [1:0] FSAG_ERR_BOOT    = 2'h2;
  localparam logic [1:0] FSAG_ERR_RANGE   = 2'h3;

  typedef enum logic [4:0] {
    FSAG_IDLE  = 5'h01,
    FSAG_ERASE = 5'h02,
    FSAG_WRITE = 5'h04,
    FSAG_READ  = 5'h08,
    FSAG_DONE  = 5'h10
  } fsag_state_t;

endpackage

//--- core/fsag_link_sync.sv
// Module: link-side detector of the programming tool and session
`timescale 1ns/1ps
module fsag_link_sync
  import fsag_pkg::*;
(
  input  wire logic link_clk,
  input  wire logic presetn,
  input  wire logic pclk,
  input  wire logic tool_attached,
  input  wire logic session_req,
  output logic      attached_sync,
  output logic      session_sync
);

  // ************************************************************
  // Link domain: register the levels on the link clock
  // ************************************************************
  typedef struct packed {
    logic att;
    logic ses;
  } fsag_lk_t;

  fsag_lk_t lk_r, lk_nxt;

  always_comb begin
    lk_nxt     = lk_r;
    lk_nxt.att = tool_attached;
    lk_nxt.ses = session_req & tool_attached;
  end

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // ************************************************************
  // System domain: two-flop synchronisers for both levels
  // ************************************************************
  typedef struct packed {
    logic [1:0] att;
    logic [1:0] ses;
  } fsag_sy_t;

  fsag_sy_t sy_r, sy_nxt;

  always_comb begin
    sy_nxt     = sy_r;
    sy_nxt.att = {sy_r.att[0], lk_r.att};
    sy_nxt.ses = {sy_r.ses[0], lk_r.ses};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy_r <= '0;
    end else begin
      sy_r <= sy_nxt;
    end
  end

  assign attached_sync = sy_r.att[1];
  assign session_sync  = sy_r.ses[1];

endmodule // fsag_link_sync

//--- core/fsag_guard.sv
// Module: flash sector access guard with APB control registers
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps

// Overview of operation
// - Erase either the whole array or one chosen sector.
// - Program the array one byte at a time.
// - Sector erase touches only bytes of that sector.
// - Tool or in-circuit programming may alter all sectors and option byte.
// - Application programming never alters the boot sector.
// - Sector count: 4K has one, 8K two, larger three.
// - Sectors 0 and 1 are 4 Kbytes at top; boot sector is F000h-FFFFh.
// - Read-out lock blocks external reads and all array writes.
// - Removing the lock first erases the whole array.
// - The lock is one bit of the option byte, which reset clears to 00h.
// - Serial link pins are withheld from the application while a tool is attached.
// - Control register at 0024h, resets to 00h, runs program and erase.
module fsag_guard
  import fsag_pkg::*;
#(
  parameter int FLASH_BYTES = 16384
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        link_clk,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tool_attached,
  input  wire logic        incircuit_comm_mode,
  input  wire logic        offboard_programmer,
  input  wire logic        app_serial_clock_out,
  input  wire logic        app_serial_data_out,
  output logic             incircuit_serial_clock_app_en,
  output logic             incircuit_serial_data_app_en,
  output logic             readout_lock_option
);

  localparam int AW = $clog2(FLASH_BYTES);
  localparam logic [15:0] BASE_ADDR = 16'(32'h10000 - FLASH_BYTES);

  // ************************************************************
  // Link crossing
  // ************************************************************
  logic attached_sync;
  logic session_sync;

  fsag_link_sync u_link (
    .link_clk      (link_clk),
    .presetn       (presetn),
    .pclk          (pclk),
    .tool_attached (tool_attached),
    .session_req   (incircuit_comm_mode),
    .attached_sync (attached_sync),
    .session_sync  (session_sync)
  );

  // Off-board strap passes two flops before use
  logic [1:0] offb_sync_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offb_sync_r <= 2'h0;
    end else begin
      offb_sync_r <= {offb_sync_r[0], offboard_programmer};
    end
  end

  // ************************************************************
  // Address decode helpers
  // ************************************************************
  // Sector index of an address; 3 means outside the array
  function automatic logic [1:0] sector_of(input logic [15:0] a);
    logic [1:0] s;
    s = 2'h3;
    if (a >= FSAG_SECTOR0_BASE) begin
      s = 2'h0;
    end else if (FLASH_BYTES > FSAG_SIZE_4K && a >= FSAG_SECTOR1_BASE) begin
      s = 2'h1;
    end else if (FLASH_BYTES > FSAG_SIZE_8K && a >= BASE_ADDR) begin
      s = 2'h2;
    end
    return s;
  endfunction

  function automatic logic [AW-1:0] index_of(input logic [15:0] a);
    return AW'(a - BASE_ADDR);
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    fsag_state_t      st;
    logic [7:0]       ctrl;
    logic [15:0]      addr;
    logic [7:0]       data;
    logic [7:0]       rdata;
    logic [7:0]       option;
    logic [1:0]       err;
    logic             done;
    logic [1:0]       esect;
    logic             emass;
    logic [AW-1:0]    cnt;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             clk_en;
    logic             dat_en;
  } fsag_reg_t;

  fsag_reg_t  s_r, s_nxt;
  logic [7:0] mem_r [FLASH_BYTES];

  // Array write port decided by the sequencer
  logic          mem_we;
  logic [AW-1:0] mem_wa;
  logic [7:0]    mem_wd;

  logic          setup;
  logic          wr_acc;
  logic          boot_lock;
  logic          tool_mode;
  logic [1:0]    sect;

  always_comb begin
    setup     = psel & ~penable;
    wr_acc    = psel & penable & pwrite;
    tool_mode = session_sync | offb_sync_r[1];
    boot_lock = ~tool_mode;
    sect      = sector_of(s_r.addr);
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    s_nxt   = s_r;
    mem_we  = 1'b0;
    mem_wa  = index_of(s_r.addr);
    mem_wd  = s_r.data;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    s_nxt.clk_en  = ~attached_sync & app_serial_clock_out;
    s_nxt.dat_en  = ~attached_sync & app_serial_data_out;

    // APB: answer one cycle after setup
    if (setup) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0000_0000;
      case (paddr)
        FSAG_ADDR_CTRL:   s_nxt.prdata = {24'h0, s_r.ctrl};
        FSAG_ADDR_STATUS: s_nxt.prdata = {24'h0, 3'h0, attached_sync, tool_mode,
                                          s_r.err, s_r.done};
        FSAG_ADDR_ADDR:   s_nxt.prdata = {16'h0, s_r.addr};
        FSAG_ADDR_DATA:   s_nxt.prdata = {24'h0, s_r.data};
        FSAG_ADDR_OPTION: s_nxt.prdata = {24'h0, s_r.option};
        FSAG_ADDR_RDATA:  s_nxt.prdata = {24'h0, s_r.rdata};
        default:          s_nxt.pslverr = 1'b1;
      endcase
    end

    if (wr_acc && s_r.pready && !s_r.pslverr) begin
      case (paddr)
        FSAG_ADDR_ADDR: s_nxt.addr = pwdata[15:0];
        FSAG_ADDR_DATA: s_nxt.data = pwdata[7:0];
        FSAG_ADDR_OPTION: s_nxt.data = pwdata[7:0];
        FSAG_ADDR_CTRL: begin
          if (s_r.st == FSAG_IDLE) begin
            s_nxt.ctrl = pwdata[7:0];
            s_nxt.done = 1'b0;
            s_nxt.err  = FSAG_ERR_NONE;
          end
        end
        default: s_nxt.done = s_r.done;
      endcase
    end

    // Sequencer
    case (s_r.st)
      FSAG_IDLE: begin
        if (s_r.ctrl[FSAG_CTRL_OPTWR]) begin
          if (!tool_mode) begin
            s_nxt.err = FSAG_ERR_BOOT;
            s_nxt.st  = FSAG_DONE;
          end else if (s_r.option[FSAG_OPT_LOCK] && !s_r.data[FSAG_OPT_LOCK]) begin
            s_nxt.emass = 1'b1;
            s_nxt.cnt   = '0;
            s_nxt.st    = FSAG_ERASE;
          end else begin
            s_nxt.option = s_r.data;
            s_nxt.st     = FSAG_DONE;
          end
        end else if (s_r.ctrl[FSAG_CTRL_MERASE] || s_r.ctrl[FSAG_CTRL_SERASE]
                     || s_r.ctrl[FSAG_CTRL_PROG]) begin
          if (s_r.option[FSAG_OPT_LOCK]) begin
            s_nxt.err = FSAG_ERR_LOCKED;
            s_nxt.st  = FSAG_DONE;
          end else if (s_r.ctrl[FSAG_CTRL_MERASE]) begin
            if (boot_lock) begin
              s_nxt.err = FSAG_ERR_BOOT;
              s_nxt.st  = FSAG_DONE;
            end else begin
              s_nxt.emass = 1'b1;
              s_nxt.cnt   = '0;
              s_nxt.st    = FSAG_ERASE;
            end
          end else if (sect == 2'h3) begin
            s_nxt.err = FSAG_ERR_RANGE;
            s_nxt.st  = FSAG_DONE;
          end else if (sect == 2'h0 && boot_lock) begin
            s_nxt.err = FSAG_ERR_BOOT;
            s_nxt.st  = FSAG_DONE;
          end else if (s_r.ctrl[FSAG_CTRL_SERASE]) begin
            s_nxt.emass = 1'b0;
            s_nxt.esect = sect;
            s_nxt.cnt   = '0;
            s_nxt.st    = FSAG_ERASE;
          end else begin
            s_nxt.st = FSAG_WRITE;
          end
        end else if (s_r.ctrl[FSAG_CTRL_READ]) begin
          if (s_r.option[FSAG_OPT_LOCK] && tool_mode) begin
            s_nxt.err = FSAG_ERR_LOCKED;
            s_nxt.st  = FSAG_DONE;
          end else if (sect == 2'h3) begin
            s_nxt.err = FSAG_ERR_RANGE;
            s_nxt.st  = FSAG_DONE;
          end else begin
            s_nxt.st = FSAG_READ;
          end
        end
      end
      FSAG_ERASE: begin
        // One byte per cycle; sector erase stays inside its sector
        mem_wa = s_r.cnt;
        mem_wd = FSAG_ERASED_BYTE;
        mem_we = s_r.emass ||
                 (sector_of(16'(BASE_ADDR + 16'(s_r.cnt))) == s_r.esect);
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (s_r.cnt == AW'(FLASH_BYTES - 1)) begin
          if (s_r.ctrl[FSAG_CTRL_OPTWR]) begin
            s_nxt.option = s_r.data;
          end
          s_nxt.st = FSAG_DONE;
        end
      end
      FSAG_WRITE: begin
        mem_we   = 1'b1;
        s_nxt.st = FSAG_DONE;
      end
      FSAG_READ: begin
        s_nxt.rdata = mem_r[index_of(s_r.addr)];
        s_nxt.st    = FSAG_DONE;
      end
      FSAG_DONE: begin
        s_nxt.ctrl = FSAG_CTRL_RESET;
        s_nxt.done = 1'b1;
        s_nxt.st   = FSAG_IDLE;
      end
      default: s_nxt.st = FSAG_IDLE;
    endcase
  end

  // ************************************************************
  // Registers and array
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r        <= '0;
      s_r.st     <= FSAG_IDLE;
      s_r.ctrl   <= FSAG_CTRL_RESET;
      s_r.clk_en <= 1'b0;
      s_r.dat_en <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem_r[mem_wa] <= mem_wd;
    end
  end

  assign prdata  = s_r.prdata;
  assign pready  = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign incircuit_serial_clock_app_en = s_r.clk_en;
  assign incircuit_serial_data_app_en  = s_r.dat_en;
  assign readout_lock_option = s_r.option[FSAG_OPT_LOCK];

endmodule // fsag_guard

//--- test/fsag_guard_assertions.sv
// Checker: port-level properties of the flash sector access guard
`timescale 1ns/1ps
module fsag_guard_checker
  import fsag_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tool_attached,
  input wire logic        incircuit_comm_mode,
  input wire logic        app_serial_clock_out,
  input wire logic        incircuit_serial_clock_app_en,
  input wire logic        incircuit_serial_data_app_en,
  input wire logic        readout_lock_option
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic setup = psel && !penable;
  wire logic mapped = paddr inside {FSAG_ADDR_CTRL, FSAG_ADDR_STATUS, FSAG_ADDR_ADDR,
                                    FSAG_ADDR_DATA, FSAG_ADDR_OPTION, FSAG_ADDR_RDATA};
  // ****
  // Bus answer
  // ****
  a_ready_after_setup:
    assert property (setup |=> pready) else $error("pready missing");
  a_ready_one_pulse:
    assert property (pready |=> !pready) else $error("pready too long");
  a_err_on_unmapped:
    assert property (setup && !mapped |=> pslverr) else $error("unmapped not refused");
  a_no_err_mapped:
    assert property (setup && mapped |=> !pslverr) else $error("mapped refused");
  a_ctrl_byte_wide:
    assert property (pready && !pwrite && paddr == FSAG_ADDR_CTRL |-> prdata[31:8] == 24'h0)
      else $error("control upper bits set");
  a_clk_pin_held:
    assert property (tool_attached [*8] ##1 tool_attached |=> !incircuit_serial_clock_app_en)
      else $error("clock pin given to application");
  a_data_pin_held:
    assert property (tool_attached [*8] ##1 tool_attached |=> !incircuit_serial_data_app_en)
      else $error("data pin given to application");
  a_pin_needs_app:
    assert property (!app_serial_clock_out |=> !incircuit_serial_clock_app_en)
      else $error("clock pin enabled unrequested");
  c_unmapped: cover property (setup && !mapped);
  c_lock_set: cover property ($rose(readout_lock_option));
  c_session: cover property (tool_attached && incircuit_comm_mode);
endmodule // fsag_guard_checker

//--- test/fsag_tool_model.sv
// Model: external programming tool on the in-circuit link
`timescale 1ns/1ps
module fsag_tool_model (
  input  wire logic link_clk,
  input  wire logic plug,
  input  wire logic session,
  output logic      tool_attached,
  output logic      incircuit_comm_mode,
  output logic      tool_rstn
);
  initial begin
    tool_attached = 1'b0;
    incircuit_comm_mode = 1'b0;
    tool_rstn = 1'b1;
  end
  // Mode only entered while plugged; reset stays released during a session
  always @(posedge link_clk) begin
    tool_attached <= plug;
    incircuit_comm_mode <= plug && session;
    tool_rstn <= 1'b1;
  end
endmodule // fsag_tool_model

//--- test/fsag_guard_test.sv
// Testbench: flash sector access guard through APB and a tool model
`timescale 1ns/1ps
module fsag_guard_test import fsag_pkg::*;;
  logic        pclk, rst_b, link_clk, psel, penable, pwrite, plug, session;
  logic        app_clk, app_dat, pready, pslverr, tool_attached, mode_on, tool_rstn;
  logic        clk_en, dat_en, lock;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int          num_errors, n_checks, cyc;
  wire logic   presetn = rst_b && tool_rstn;

  fsag_tool_model tool (.link_clk, .plug, .session, .tool_attached,
    .incircuit_comm_mode(mode_on), .tool_rstn);
  fsag_guard #(.FLASH_BYTES(8192)) dut (.pclk, .presetn, .link_clk, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tool_attached, .incircuit_comm_mode(mode_on),
    .offboard_programmer(1'b0), .app_serial_clock_out(app_clk), .app_serial_data_out(app_dat),
    .incircuit_serial_clock_app_en(clk_en), .incircuit_serial_data_app_en(dat_en),
    .readout_lock_option(lock));

  // ****
  // Bus and compare tasks
  // ****
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] x, input string m);
    n_checks++;
    if (g !== x) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic chk_err(input logic [1:0] g, input logic [1:0] x, input string m);
    chk_reg({30'h0, g}, {30'h0, x}, m);
  endtask
  // Loads address and data, starts one command, waits for the self-clear
  task automatic cmd(input logic [15:0] a, input logic [11:0] da, input logic [7:0] d,
                     input int b, output logic [31:0] st);
    logic [31:0] q;
    logic        e;
    apb(FSAG_ADDR_ADDR, 1, {16'h0, a}, q, e);
    apb(da, 1, {24'h0, d}, q, e);
    apb(FSAG_ADDR_CTRL, 1, 32'h1 << b, q, e);
    do apb(FSAG_ADDR_CTRL, 0, 32'h0, q, e); while (q !== 32'h0);
    apb(FSAG_ADDR_STATUS, 0, 32'h0, st, e);
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] st, output logic [31:0] q);
    logic e;
    cmd(a, FSAG_ADDR_DATA, 8'h00, FSAG_CTRL_READ, st);
    apb(FSAG_ADDR_RDATA, 0, 32'h0, q, e);
  endtask
  task automatic link(input logic on);
    plug <= on;
    session <= on;
    repeat (20) @(posedge pclk);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    apb(FSAG_ADDR_CTRL, 0, 32'h0, q, e);
    chk_reg(q, {24'h0, FSAG_CTRL_RESET}, "control reset");
    apb(12'h040, 1, 32'hFF, q, e);
    chk_reg({31'h0, e}, 32'h1, "unmapped accepted");
  endtask
  task automatic t_tool;
    logic [31:0] st, q;
    link(1);
    chk_reg({30'h0, clk_en, dat_en}, 32'h0, "pins not withheld");
    cmd(16'h0000, FSAG_ADDR_DATA, 8'h00, FSAG_CTRL_MERASE, st);
    chk_err(st[2:1], FSAG_ERR_NONE, "whole erase");
    cmd(16'hF000, FSAG_ADDR_DATA, 8'h5A, FSAG_CTRL_PROG, st);
    chk_err(st[2:1], FSAG_ERR_NONE, "boot program");
    cmd(16'hF001, FSAG_ADDR_DATA, 8'h33, FSAG_CTRL_PROG, st);
    cmd(16'hE123, FSAG_ADDR_DATA, 8'hA5, FSAG_CTRL_PROG, st);
    cmd(16'hE000, FSAG_ADDR_DATA, 8'h00, FSAG_CTRL_SERASE, st);
    chk_err(st[2:1], FSAG_ERR_NONE, "sector erase");
    rd(16'hE123, st, q);
    chk_reg(q, {24'h0, FSAG_ERASED_BYTE}, "sector kept");
    rd(16'hF000, st, q);
    chk_reg(q, 32'h5A, "neighbour byte hit");
    cmd(16'hDFFF, FSAG_ADDR_DATA, 8'h11, FSAG_CTRL_PROG, st);
    chk_err(st[2:1], FSAG_ERR_RANGE, "beyond array");
  endtask
  task automatic t_app;
    logic [31:0] st, q;
    link(0);
    chk_reg({30'h0, clk_en, dat_en}, 32'h3, "pins not returned");
    app_clk <= 0;
    @(posedge pclk);
    @(posedge pclk);
    chk_reg({31'h0, clk_en}, 32'h0, "pin enabled unrequested");
    app_clk <= 1;
    cmd(16'hF001, FSAG_ADDR_DATA, 8'h00, FSAG_CTRL_PROG, st);
    chk_err(st[2:1], FSAG_ERR_BOOT, "boot write taken");
    cmd(16'hF000, FSAG_ADDR_DATA, 8'h00, FSAG_CTRL_SERASE, st);
    chk_err(st[2:1], FSAG_ERR_BOOT, "boot erase taken");
    cmd(16'hE010, FSAG_ADDR_DATA, 8'h3C, FSAG_CTRL_PROG, st);
    chk_err(st[2:1], FSAG_ERR_NONE, "app write refused");
    rd(16'hF001, st, q);
    chk_reg(q, 32'h33, "boot byte changed");
  endtask
  task automatic t_lock;
    logic [31:0] st, q;
    link(1);
    cmd(16'h0000, FSAG_ADDR_OPTION, 8'h01, FSAG_CTRL_OPTWR, st);
    chk_reg({31'h0, lock}, 32'h1, "lock not set");
    cmd(16'hE020, FSAG_ADDR_DATA, 8'h77, FSAG_CTRL_PROG, st);
    chk_err(st[2:1], FSAG_ERR_LOCKED, "write under lock");
    rd(16'hE010, st, q);
    chk_err(st[2:1], FSAG_ERR_LOCKED, "read under lock");
    cmd(16'h0000, FSAG_ADDR_OPTION, 8'h00, FSAG_CTRL_OPTWR, st);
    chk_reg({31'h0, lock}, 32'h0, "lock not cleared");
    rd(16'hE010, st, q);
    chk_reg(q, {24'h0, FSAG_ERASED_BYTE}, "array kept");
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    link_clk = 0;
    #3;
    forever #16 link_clk = ~link_clk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      final_report;
    end
  end
  initial begin
    {rst_b, psel, penable, pwrite, plug, session} = '0;
    {app_clk, app_dat} = 2'h3;
    paddr = '0;
    pwdata = '0;
    repeat (5) @(posedge pclk);
    rst_b <= 1;
    @(posedge pclk);
    t_regs;
    t_tool;
    t_app;
    t_lock;
    final_report;
  end
endmodule // fsag_guard_test

bind fsag_guard fsag_guard_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .tool_attached, .incircuit_comm_mode, .app_serial_clock_out,
  .incircuit_serial_clock_app_en, .incircuit_serial_data_app_en, .readout_lock_option);
